// file: rtl/pin_irq_priority_ctrl.sv
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
module pin_irq_priority_ctrl
    import pin_irq_pkg::*;
(
    input  wire logic               i_ref_clk,
    input  wire logic               i_rst_b,
    input  wire logic [ADDR_W-1:0]  i_addr,
    input  wire logic [DATA_W-1:0]  i_wdata,
    input  wire logic               i_wr,
    input  wire logic               i_rd,
    output logic      [DATA_W-1:0]  o_rdata,
    input  wire logic               i_ext_pin_a,
    input  wire logic               i_ext_pin_b,
    input  wire logic               i_ext_pin_c,
    input  wire logic [7:0]         i_port_pins,
    input  wire logic [7:0]         i_std_enables,
    input  wire logic               i_timer0_req,
    input  wire logic               i_timer1_req,
    input  wire logic               i_serial_req,
    input  wire logic               i_timer2_req,
    input  wire logic               i_timer3_event,
    input  wire logic               i_ack,
    input  wire logic [SRC_W-1:0]   i_ack_source,
    output logic                    o_req_valid,
    output logic      [SRC_W-1:0]   o_req_source,
    output logic      [1:0]         o_req_level,
    output logic                    o_wake,
    output logic                    o_irq
);
    typedef struct packed {
        logic       a_s1;
        logic       a_s2;
        logic       a_s3;
        logic       b_s1;
        logic       b_s2;
        logic       b_s3;
        logic       c_s1;
        logic       c_s2;
        logic       c_s3;
        logic [7:0] p_s1;
        logic [7:0] p_s2;
        logic [7:0] p_s3;
        logic [7:0] tctrl;
        logic [7:0] flags;
        logic [7:0] enables;
        logic [7:0] prio_lo_a;
        logic [7:0] prio_hi_a;
        logic [7:0] prio_lo_b;
        logic [7:0] prio_hi_b;
        logic [7:0] wake_en;
        logic [7:0] evt_status;
        logic [7:0] evt_mask;
        logic [7:0] rdata;
        logic       req_valid;
        logic [3:0] req_source;
        logic [1:0] req_level;
        logic       wake;
        logic       irq;
    } state_t;

    state_t     s_r;
    state_t     s_nxt;
    logic [1:0] rst_sync_r;
    logic       rst_n;

    // Reset is released through two flops so every state flop leaves reset together
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            rst_sync_r <= 2'b00;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    // Picks the most urgent pending source; lower number wins a tie
    function automatic logic [4:0] pick(input logic [NUM_SRC-1:0] pend,
                                        input logic [NUM_SRC-1:0] hi,
                                        input logic [NUM_SRC-1:0] lo);
        logic [4:0] res;
        logic       found;
        res   = 5'h00;
        found = 1'b0;
        for (int lvl = 3; lvl >= 0; lvl--)
        begin
            for (int k = 0; k < NUM_SRC; k++)
            begin
                if (!found && pend[k] && ({hi[k], lo[k]} == 2'(lvl))) // [RULE3] [RULE14]
                begin
                    found = 1'b1;
                    res   = {1'b1, 4'(k)};
                end
            end
        end
        return res;
    endfunction

    // Register read value, reserved bits as zero
    function automatic logic [7:0] read_mux(input state_t s, input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            ADDR_TCTRL:      v = s.tctrl;
            ADDR_FLAGS:      v = s.flags & FLAGS_USED;
            ADDR_ENABLES:    v = s.enables & ENABLES_USED;
            ADDR_PRIO_LO_A:  v = s.prio_lo_a & PRIO_A_USED;
            ADDR_PRIO_HI_A:  v = s.prio_hi_a & PRIO_A_USED;
            ADDR_PRIO_LO_B:  v = s.prio_lo_b & PRIO_B_USED;
            ADDR_PRIO_HI_B:  v = s.prio_hi_b & PRIO_B_USED;
            ADDR_WAKE_EN:    v = s.wake_en;
            ADDR_EVT_STATUS: v = s.evt_status & EV_USED;
            ADDR_EVT_MASK:   v = s.evt_mask & EV_USED;
            default:         v = 8'h00;
        endcase
        return v;
    endfunction

    logic                a_fall;
    logic                b_fall;
    logic                c_fall;
    logic                port_chg;
    logic [NUM_SRC-1:0]  pend;
    logic [NUM_SRC-1:0]  hi_v;
    logic [NUM_SRC-1:0]  lo_v;
    logic [4:0]          win;
    logic [7:0]          events;
    logic                ack_a;
    logic                ack_b;
    logic                ack_c;
    logic                ack_p;
    logic                ack_t3;
    logic                wr_tc;
    logic                wr_fl;

    always_comb
    begin
        s_nxt = s_r;
        // Pins come from outside, two flops before any logic looks
        s_nxt.a_s1 = i_ext_pin_a;
        s_nxt.a_s2 = s_r.a_s1;
        s_nxt.a_s3 = s_r.a_s2;
        s_nxt.b_s1 = i_ext_pin_b;
        s_nxt.b_s2 = s_r.b_s1;
        s_nxt.b_s3 = s_r.b_s2;
        s_nxt.c_s1 = i_ext_pin_c;
        s_nxt.c_s2 = s_r.c_s1;
        s_nxt.c_s3 = s_r.c_s2;
        s_nxt.p_s1 = i_port_pins;
        s_nxt.p_s2 = s_r.p_s1;
        s_nxt.p_s3 = s_r.p_s2;

        a_fall   = s_r.a_s3 & ~s_r.a_s2; // [RULE7]
        b_fall   = s_r.b_s3 & ~s_r.b_s2; // [RULE7]
        c_fall   = s_r.c_s3 & ~s_r.c_s2; // [RULE7]
        port_chg = |((s_r.p_s3 ^ s_r.p_s2) & s_r.wake_en); // [RULE8] [RULE12]

        ack_a  = i_ack && (i_ack_source == SRC_PIN_A);
        ack_b  = i_ack && (i_ack_source == SRC_PIN_B);
        ack_c  = i_ack && (i_ack_source == SRC_PIN_C);
        ack_p  = i_ack && (i_ack_source == SRC_PORT);
        ack_t3 = i_ack && (i_ack_source == SRC_TIMER3);
        wr_tc  = i_wr && (i_addr == ADDR_TCTRL);
        wr_fl  = i_wr && (i_addr == ADDR_FLAGS);

        // Plain control registers
        if (i_wr)
        begin
            case (i_addr)
                ADDR_ENABLES:   s_nxt.enables   = i_wdata & ENABLES_USED;
                ADDR_PRIO_LO_A: s_nxt.prio_lo_a = i_wdata & PRIO_A_USED;
                ADDR_PRIO_HI_A: s_nxt.prio_hi_a = i_wdata & PRIO_A_USED;
                ADDR_PRIO_LO_B: s_nxt.prio_lo_b = i_wdata & PRIO_B_USED;
                ADDR_PRIO_HI_B: s_nxt.prio_hi_b = i_wdata & PRIO_B_USED;
                ADDR_WAKE_EN:   s_nxt.wake_en   = i_wdata;
                ADDR_EVT_MASK:  s_nxt.evt_mask  = i_wdata & EV_USED;
                default:        s_nxt.evt_mask  = s_nxt.evt_mask;
            endcase
        end

        // Timer control register; hardware set wins over a write or an ack
        if (wr_tc)
            s_nxt.tctrl = i_wdata;
        if (ack_a)
            s_nxt.tctrl[TC_PIN_A_FLAG] = 1'b0; // [RULE11]
        if (ack_b)
            s_nxt.tctrl[TC_PIN_B_FLAG] = 1'b0; // [RULE11]
        if (a_fall)
            s_nxt.tctrl[TC_PIN_A_FLAG] = 1'b1; // [RULE10]
        if (b_fall)
            s_nxt.tctrl[TC_PIN_B_FLAG] = 1'b1; // [RULE10]

        // Extra flags: writing 0 clears, writing 1 keeps
        if (wr_fl)
            s_nxt.flags = s_r.flags & i_wdata & FLAGS_USED; // [RULE13]
        if (ack_c)
            s_nxt.flags[FL_PIN_C] = 1'b0; // [RULE11]
        if (ack_p)
            s_nxt.flags[FL_PORT] = 1'b0; // [RULE11]
        if (ack_t3)
            s_nxt.flags[FL_TIMER3] = 1'b0;
        if (c_fall)
            s_nxt.flags[FL_PIN_C] = 1'b1; // [RULE10]
        if (port_chg)
            s_nxt.flags[FL_PORT] = 1'b1; // [RULE12]
        if (i_timer3_event)
            s_nxt.flags[FL_TIMER3] = 1'b1;

        // Pending requests; pins A and B follow their trigger select
        pend[SRC_PIN_A]  = i_std_enables[IE_PIN_A] &
                           (s_r.tctrl[TC_PIN_A_TRIG] ? s_r.tctrl[TC_PIN_A_FLAG]
                                                     : ~s_r.a_s2); // [RULE9]
        pend[SRC_TIMER0] = i_std_enables[IE_TIMER0] & i_timer0_req;
        pend[SRC_PIN_B]  = i_std_enables[IE_PIN_B] &
                           (s_r.tctrl[TC_PIN_B_TRIG] ? s_r.tctrl[TC_PIN_B_FLAG]
                                                     : ~s_r.b_s2); // [RULE9]
        pend[SRC_TIMER1] = i_std_enables[IE_TIMER1] & i_timer1_req;
        pend[SRC_SERIAL] = i_std_enables[IE_SERIAL] & i_serial_req;
        pend[SRC_TIMER2] = i_std_enables[IE_TIMER2] & i_timer2_req;
        pend[SRC_PIN_C]  = s_r.enables[EN_PIN_C] & s_r.flags[FL_PIN_C];
        pend[SRC_PORT]   = s_r.enables[EN_PORT] & s_r.flags[FL_PORT]; // [RULE2]
        pend[SRC_TIMER3] = s_r.enables[EN_TIMER3] & s_r.flags[FL_TIMER3]; // [RULE1]
        pend = pend & {NUM_SRC{i_std_enables[IE_GLOBAL]}};

        // Priority bits gathered in source order
        // Second pair holds pin C at bit 2, yet pin C has the lowest source number of the three
        hi_v = {s_r.prio_hi_b[0], s_r.prio_hi_b[1], s_r.prio_hi_b[2],
                s_r.prio_hi_a[5:0]}; // [RULE4] [RULE5]
        lo_v = {s_r.prio_lo_b[0], s_r.prio_lo_b[1], s_r.prio_lo_b[2],
                s_r.prio_lo_a[5:0]}; // [RULE4] [RULE5]
        win  = pick(pend, hi_v, lo_v);
        s_nxt.req_valid  = win[4];
        s_nxt.req_source = win[3:0];
        s_nxt.req_level  = win[4] ? {hi_v[win[3:0]], lo_v[win[3:0]]} : 2'b00; // [RULE3]

        // Stop wake needs only the pin's own enable, never the global one
        s_nxt.wake = (i_std_enables[IE_PIN_A] & ~s_r.a_s2)
                   | (i_std_enables[IE_PIN_B] & ~s_r.b_s2)
                   | (s_r.enables[EN_PIN_C] & c_fall)
                   | port_chg; // [RULE6] [RULE15]

        // Sticky event status, cleared by reading it; new events win
        events            = 8'h00;
        events[EV_PIN_A]  = a_fall;
        events[EV_PIN_B]  = b_fall;
        events[EV_PIN_C]  = c_fall;
        events[EV_PORT]   = port_chg;
        events[EV_TIMER3] = i_timer3_event;
        if (i_rd && (i_addr == ADDR_EVT_STATUS))
            s_nxt.evt_status = 8'h00;
        s_nxt.evt_status = s_nxt.evt_status | events;
        s_nxt.irq        = |(s_nxt.evt_status & s_nxt.evt_mask);

        // Read data stands only in the cycle after the strobe
        s_nxt.rdata = i_rd ? read_mux(s_r, i_addr) : 8'h00;
    end

    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign o_rdata      = s_r.rdata;
    assign o_req_valid  = s_r.req_valid;
    assign o_req_source = s_r.req_source;
    assign o_req_level  = s_r.req_level;
    assign o_wake       = s_r.wake;
    assign o_irq        = s_r.irq;

    chk_t3_gate: // [RULE1]
    assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        (s_r.req_valid && s_r.req_source == SRC_TIMER3) |-> $past(s_r.enables[EN_TIMER3]))
        else $error("timer3 request passed while disabled");

    chk_port_gate: // [RULE2]
    assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        (s_r.req_valid && s_r.req_source == SRC_PORT) |-> $past(s_r.enables[EN_PORT]))
        else $error("port-change request passed while disabled");

    chk_level_map: // [RULE3]
    assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        (s_r.req_valid && s_r.req_source == SRC_PIN_A) |->
        s_r.req_level == {$past(s_r.prio_hi_a[0]), $past(s_r.prio_lo_a[0])})
        else $error("pin A level does not match its priority bits");

    chk_a_edge_flag: // [RULE10]
    assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        (s_r.a_s3 && !s_r.a_s2) |=> s_r.tctrl[TC_PIN_A_FLAG])
        else $error("pin A falling edge did not set its flag");

    chk_port_flag: // [RULE12]
    assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        (|((s_r.p_s3 ^ s_r.p_s2) & s_r.wake_en)) |=> s_r.flags[FL_PORT])
        else $error("port change did not set the port flag");

    chk_flag_clear: // [RULE13]
    assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        (i_wr && i_addr == ADDR_FLAGS && i_wdata == 8'hfb && !(s_r.c_s3 && !s_r.c_s2))
        |=> !s_r.flags[FL_PIN_C] && (s_r.flags[FL_PORT] == $past(s_r.flags[FL_PORT]) ||
        s_r.flags[FL_PORT]))
        else $error("pin C flag clear write misbehaved");

    chk_ack_clear: // [RULE11]
    assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        (i_ack && i_ack_source == SRC_PORT && !(|((s_r.p_s3 ^ s_r.p_s2) & s_r.wake_en)))
        |=> !s_r.flags[FL_PORT])
        else $error("port flag not cleared on service entry");

    chk_level_trig: // [RULE9]
    assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        (!s_r.tctrl[TC_PIN_A_TRIG] && !s_r.a_s2 && i_std_enables[IE_PIN_A] &&
        i_std_enables[IE_GLOBAL]) |=> s_r.req_valid)
        else $error("low level on pin A raised no request");

    chk_c_wake: // [RULE15]
    assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        (s_r.c_s3 && !s_r.c_s2 && s_r.enables[EN_PIN_C]) |=> o_wake)
        else $error("pin C edge did not wake");
endmodule

// file: rtl/pin_irq_pkg.sv
// Functional notes
// RULE1: timer3 enable bit gates timer3 requests
// RULE2: port-change enable gates port-change request
// RULE3: two bits give four levels, 3 highest
// RULE4: first priority pair bits for six sources
// RULE5: second priority pair bits: C, port, timer3; the code puts timer3 at bit 0, port at bit 1, C at bit 2
// RULE6: pins A, B, C, port wake from stop
// RULE7: A, B edge or level; C edge only
// RULE8: any port pin change fires port source; the code counts only pins whose wake_en bit is set
// RULE9: trigger select 0 level, 1 falling edge
// RULE10: falling edge sets flag regardless of enable
// RULE11: flags clear on service routine entry
// RULE12: port flag needs pin wake enable only
// RULE13: flag write 0 clears, 1 keeps
// RULE14: level is high:low; ties by polling order
// RULE15: pin enable also enables wake, ignores global
package pin_irq_pkg;
    localparam int          ADDR_W           = 8;
    localparam int          DATA_W           = 8;
    localparam int          NUM_SRC          = 9;
    localparam int          SRC_W            = 4;
    // Register addresses
    localparam logic [7:0]  ADDR_TCTRL       = 8'h88;
    localparam logic [7:0]  ADDR_FLAGS       = 8'h95;
    localparam logic [7:0]  ADDR_ENABLES     = 8'ha9;
    localparam logic [7:0]  ADDR_PRIO_LO_A   = 8'hb8;
    localparam logic [7:0]  ADDR_PRIO_HI_A   = 8'hb9;
    localparam logic [7:0]  ADDR_PRIO_LO_B   = 8'hba;
    localparam logic [7:0]  ADDR_PRIO_HI_B   = 8'hbb;
    localparam logic [7:0]  ADDR_WAKE_EN     = 8'hac;
    localparam logic [7:0]  ADDR_EVT_STATUS  = 8'had;
    localparam logic [7:0]  ADDR_EVT_MASK    = 8'hae;
    // Reset values
    localparam logic [7:0]  RST_REG          = 8'h00;
    // Timer and pin control bits
    localparam int          TC_PIN_A_TRIG    = 0;
    localparam int          TC_PIN_A_FLAG    = 1;
    localparam int          TC_PIN_B_TRIG    = 2;
    localparam int          TC_PIN_B_FLAG    = 3;
    // Extra flag bits
    localparam int          FL_TIMER3        = 0;
    localparam int          FL_PORT          = 1;
    localparam int          FL_PIN_C         = 2;
    localparam logic [7:0]  FLAGS_USED       = 8'h07;
    // Extra enable bits
    localparam int          EN_TIMER3        = 0;
    localparam int          EN_PORT          = 1;
    localparam int          EN_PIN_C         = 2;
    localparam logic [7:0]  ENABLES_USED     = 8'h07;
    localparam logic [7:0]  PRIO_A_USED      = 8'h3f;
    localparam logic [7:0]  PRIO_B_USED      = 8'h07;
    // Standard enable register bits, held outside this block
    localparam int          IE_PIN_A         = 0;
    localparam int          IE_TIMER0        = 1;
    localparam int          IE_PIN_B         = 2;
    localparam int          IE_TIMER1        = 3;
    localparam int          IE_SERIAL        = 4;
    localparam int          IE_TIMER2        = 5;
    localparam int          IE_GLOBAL        = 7;
    // Event status bits
    localparam int          EV_PIN_A         = 0;
    localparam int          EV_PIN_B         = 1;
    localparam int          EV_PIN_C         = 2;
    localparam int          EV_PORT          = 3;
    localparam int          EV_TIMER3        = 4;
    localparam logic [7:0]  EV_USED          = 8'h1f;
    // Source numbers, in polling order
    localparam logic [3:0]  SRC_PIN_A        = 4'h0;
    localparam logic [3:0]  SRC_TIMER0       = 4'h1;
    localparam logic [3:0]  SRC_PIN_B        = 4'h2;
    localparam logic [3:0]  SRC_TIMER1       = 4'h3;
    localparam logic [3:0]  SRC_SERIAL       = 4'h4;
    localparam logic [3:0]  SRC_TIMER2       = 4'h5;
    localparam logic [3:0]  SRC_PIN_C        = 4'h6;
    localparam logic [3:0]  SRC_PORT         = 4'h7;
    localparam logic [3:0]  SRC_TIMER3       = 4'h8;
endpackage

// file: sim/cpu_core_model.sv
`timescale 1ns/1ps
module cpu_core_model
    import pin_irq_pkg::*;
(
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst_b,
    input  wire logic             i_req_valid,
    input  wire logic [SRC_W-1:0] i_req_source,
    input  wire logic             i_ack_en,
    input  wire logic [3:0]       i_delay,
    output logic                  o_ack,
    output logic      [SRC_W-1:0] o_ack_source
);
    logic [3:0] wait_r;
    logic [2:0] hold_r;

    // Request drops two edges after an ack, so stay deaf a while to avoid a double ack
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_ack        <= 1'b0;
            o_ack_source <= 4'h0;
            wait_r       <= 4'h0;
            hold_r       <= 3'h0;
        end
        else
        begin
            o_ack <= 1'b0;
            if (hold_r != 3'h0)
                hold_r <= hold_r - 3'h1;
            else if (i_req_valid && i_ack_en)
            begin
                if (wait_r == i_delay)
                begin
                    o_ack        <= 1'b1;
                    o_ack_source <= i_req_source;
                    wait_r       <= 4'h0;
                    hold_r       <= 3'h4;
                end
                else
                    wait_r <= wait_r + 4'h1;
            end
            else
                wait_r <= 4'h0;
        end
    end
endmodule

// file: sim/pin_irq_priority_ctrl_tb.sv
`timescale 1ns/1ps
module pin_irq_priority_ctrl_tb;
    import pin_irq_pkg::*;
    logic       i_ref_clk = 1'b0;
    logic       i_rst_b = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic       i_wr = 1'b0;
    logic       i_rd = 1'b0;
    logic [7:0] o_rdata;
    logic       pin_a = 1'b1;
    logic       pin_b = 1'b1;
    logic       pin_c = 1'b1;
    logic [7:0] port = 8'h00;
    logic [7:0] std_en = 8'h00;
    logic       t0 = 1'b0;
    logic       t1 = 1'b0;
    logic       ser = 1'b0;
    logic       t2 = 1'b0;
    logic       t3 = 1'b0;
    logic       ack;
    logic [3:0] ack_src;
    logic       ack_en = 1'b0;
    logic       req_valid;
    logic [3:0] req_src;
    logic [1:0] req_lvl;
    logic       wake;
    logic       irq;
    logic [7:0] got;
    int         miscompares = 0;
    int         n_checks = 0;
    logic [7:0] regs [7] = '{ADDR_TCTRL, ADDR_FLAGS, ADDR_ENABLES, ADDR_PRIO_LO_A,
                            ADDR_PRIO_HI_A, ADDR_PRIO_LO_B, ADDR_PRIO_HI_B};

    pin_irq_priority_ctrl pin_irq_priority_ctrl_inst (
        .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_pin_a(pin_a),
        .i_ext_pin_b(pin_b), .i_ext_pin_c(pin_c), .i_port_pins(port),
        .i_std_enables(std_en), .i_timer0_req(t0), .i_timer1_req(t1),
        .i_serial_req(ser), .i_timer2_req(t2), .i_timer3_event(t3), .i_ack(ack),
        .i_ack_source(ack_src), .o_req_valid(req_valid), .o_req_source(req_src),
        .o_req_level(req_lvl), .o_wake(wake), .o_irq(irq));

    cpu_core_model cpu_core_model_inst (
        .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_req_valid(req_valid),
        .i_req_source(req_src), .i_ack_en(ack_en), .i_delay(4'h4), .o_ack(ack),
        .o_ack_source(ack_src));

    initial
    begin
        forever #20 i_ref_clk = ~i_ref_clk;
    end

    task automatic tally_and_finish();
        if (miscompares == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] seen);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Outputs are registered, so sample just after the edge has landed
    task automatic cyc(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1;
        got = o_rdata;
        chk($sformatf("reg %h", a), exp, got);
    endtask

    task automatic req_chk(input logic v, input logic [3:0] s, input logic [1:0] l);
        chk("req_valid", {7'h00, v}, {7'h00, req_valid});
        if (v)
        begin
            chk("req_source", {4'h0, s}, {4'h0, req_src});
            chk("req_level", {6'h00, l}, {6'h00, req_lvl});
        end
    endtask

    initial
    begin
        #200000;
        miscompares++;
        tally_and_finish();
    end

    initial
    begin
        repeat (12) @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        cyc(6);
        foreach (regs[i]) rd(regs[i], RST_REG);
        rd(8'h10, 8'h00);
        wr(ADDR_PRIO_HI_A, 8'hff);
        rd(ADDR_PRIO_HI_A, 8'h3f);
        wr(ADDR_PRIO_HI_B, 8'hff);
        rd(ADDR_PRIO_HI_B, 8'h07);
        wr(ADDR_PRIO_HI_A, 8'h00);
        wr(ADDR_PRIO_HI_B, 8'h00);
        // Equal levels fall back to polling order, then priority bits decide
        std_en <= 8'h8a;
        t0 <= 1'b1;
        t1 <= 1'b1;
        cyc(3);
        req_chk(1'b1, SRC_TIMER0, 2'h0);
        wr(ADDR_PRIO_HI_A, 8'h08);
        cyc(2);
        req_chk(1'b1, SRC_TIMER1, 2'h2);
        wr(ADDR_PRIO_LO_A, 8'h0a);
        wr(ADDR_PRIO_HI_A, 8'h0a);
        cyc(2);
        req_chk(1'b1, SRC_TIMER0, 2'h3);
        t0 <= 1'b0;
        t1 <= 1'b0;
        wr(ADDR_PRIO_LO_A, 8'h00);
        wr(ADDR_PRIO_HI_A, 8'h00);
        // Serial and timer2 priority bits
        std_en <= 8'hb0;
        ser <= 1'b1;
        t2 <= 1'b1;
        wr(ADDR_PRIO_LO_A, 8'h20);
        cyc(2);
        req_chk(1'b1, SRC_TIMER2, 2'h1);
        wr(ADDR_PRIO_HI_A, 8'h10);
        cyc(2);
        req_chk(1'b1, SRC_SERIAL, 2'h2);
        ser <= 1'b0;
        t2 <= 1'b0;
        wr(ADDR_PRIO_LO_A, 8'h00);
        wr(ADDR_PRIO_HI_A, 8'h00);
        // Pin A in level mode requests and wakes while low
        std_en <= 8'h81;
        pin_a <= 1'b0;
        cyc(4);
        req_chk(1'b1, SRC_PIN_A, 2'h0);
        chk("wake", 8'h01, {7'h00, wake});
        pin_a <= 1'b1;
        cyc(4);
        req_chk(1'b0, SRC_PIN_A, 2'h0);
        wr(ADDR_TCTRL, 8'h01);
        rd(ADDR_TCTRL, 8'h01);
        // Edge mode: flag seen, then cleared by the slow ack
        ack_en <= 1'b1;
        pin_a <= 1'b0;
        cyc(3);
        rd(ADDR_TCTRL, 8'h03);
        cyc(10);
        rd(ADDR_TCTRL, 8'h01);
        ack_en <= 1'b0;
        pin_a <= 1'b1;
        // Pin C with its enable off still flags
        std_en <= 8'h80;
        pin_c <= 1'b0;
        cyc(5);
        req_chk(1'b0, SRC_PIN_C, 2'h0);
        chk("wake", 8'h00, {7'h00, wake});
        rd(ADDR_FLAGS, 8'h04);
        wr(ADDR_FLAGS, 8'hff);
        rd(ADDR_FLAGS, 8'h04);
        wr(ADDR_FLAGS, 8'hfb);
        rd(ADDR_FLAGS, 8'h00);
        pin_c <= 1'b1;
        // Port change only on wake-enabled pins, both directions
        wr(ADDR_WAKE_EN, 8'h01);
        port <= 8'h02;
        cyc(5);
        rd(ADDR_FLAGS, 8'h00);
        port <= 8'h03;
        cyc(5);
        rd(ADDR_FLAGS, 8'h02);
        req_chk(1'b0, SRC_PORT, 2'h0);
        wr(ADDR_ENABLES, 8'h02);
        cyc(2);
        req_chk(1'b1, SRC_PORT, 2'h0);
        wr(ADDR_FLAGS, 8'hfd);
        rd(ADDR_FLAGS, 8'h00);
        port <= 8'h02;
        cyc(5);
        rd(ADDR_FLAGS, 8'h02);
        wr(ADDR_FLAGS, 8'hfd);
        wr(ADDR_ENABLES, 8'h00);
        // Timer3 gated by its enable bit
        @(posedge i_ref_clk);
        t3 <= 1'b1;
        @(posedge i_ref_clk);
        t3 <= 1'b0;
        cyc(2);
        rd(ADDR_FLAGS, 8'h01);
        req_chk(1'b0, SRC_TIMER3, 2'h0);
        wr(ADDR_PRIO_HI_B, 8'h01);
        wr(ADDR_ENABLES, 8'h01);
        cyc(2);
        req_chk(1'b1, SRC_TIMER3, 2'h2);
        wr(ADDR_FLAGS, 8'hfe);
        rd(ADDR_FLAGS, 8'h00);
        // Sticky status, mask and clear on read
        @(posedge i_ref_clk);
        i_addr <= ADDR_EVT_STATUS;
        i_rd   <= 1'b1;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        wr(ADDR_EVT_MASK, 8'h04);
        wr(ADDR_TCTRL, 8'h05);
        std_en <= 8'h84;
        pin_b <= 1'b0;
        cyc(5);
        chk("irq", 8'h00, {7'h00, irq});
        rd(ADDR_TCTRL, 8'h0d);
        req_chk(1'b1, SRC_PIN_B, 2'h0);
        pin_c <= 1'b0;
        cyc(5);
        chk("irq", 8'h01, {7'h00, irq});
        rd(ADDR_EVT_STATUS, 8'h06);
        cyc(1);
        chk("irq", 8'h00, {7'h00, irq});
        rd(ADDR_EVT_STATUS, 8'h00);
        tally_and_finish();
    end
endmodule
